//--- dv/fpd_checker.sv
// Port-level assertions for the FP and privileged decoder.
// Assumes one clock domain; ce_in drops only while no output pulse stands.
`timescale 1ns/1ps
`default_nettype none
module fpd_checker
  import fpd_pkg::*;
#(parameter int ADDR_W = 32)
(
  // Clock, reset and context
  input wire logic              clock_in,
  input wire logic              rstn_in,
  input wire logic              page_8k_in,
  input wire logic [ADDR_W-1:0] areg_value_in,
  input wire logic [3:0]        reg_addr_in,
  input wire logic              reg_read_in,
  // Decoder outputs
  input wire logic [31:0]       reg_rdata_out,
  input wire logic              fp_cmd_valid_out,
  input wire logic              fp_is_power_of_two_out,
  input wire logic              fp_mem_source_out,
  input wire logic [2:0]        fp_format_out,
  input wire logic              fp_dest_write_out,
  input wire logic [7:0]        fp_exc_clear_mask_out,
  input wire logic [15:0]       status_reg_out,
  input wire logic              cache_inv_valid_out,
  input wire logic [1:0]        cache_inv_scope_out,
  input wire logic [ADDR_W-1:0] cache_inv_match_out,
  input wire logic [ADDR_W-1:0] cache_inv_mask_out,
  input wire logic              restore_valid_out,
  input wire logic [2:0]        restore_coproc_id_out,
  input wire logic              exc_privilege_out,
  input wire logic              exc_illegal_out
);
  // All checks share one clock and the async reset
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // Named one-cycle conditions: a status read, a page-scope invalidation
  sequence s_sr_read; reg_read_in && reg_addr_in == 4'h0; endsequence
  sequence s_inv_page; cache_inv_valid_out && cache_inv_scope_out == SCOPE_PAGE; endsequence

  a_sr_readback: assert property (s_sr_read |=> reg_rdata_out == {16'h0, $past(status_reg_out)})
    else $error("status read data wrong");
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero when idle");
  a_pow2_flags: assert property (fp_cmd_valid_out && fp_is_power_of_two_out |->
    fp_exc_clear_mask_out == 8'hA5 && fp_dest_write_out) else $error("power op flags wrong");
  a_test_nowrite: assert property (fp_cmd_valid_out && !fp_is_power_of_two_out |->
    !fp_dest_write_out && fp_exc_clear_mask_out == 8'hBF) else $error("test op writes");
  a_reg_ext: assert property (fp_cmd_valid_out && !fp_mem_source_out |->
    fp_format_out == FMT_EXT) else $error("register source format wrong");
  a_packed_trap: assert property (fp_cmd_valid_out |->
    !(fp_mem_source_out && fp_format_out == FMT_PACKED)) else $error("packed issued");
  a_line_mask: assert property (cache_inv_valid_out && cache_inv_scope_out == SCOPE_LINE |->
    cache_inv_mask_out == LINE_MASK) else $error("line mask wrong");
  a_page_mask: assert property (s_inv_page |->
    cache_inv_mask_out == ($past(page_8k_in) ? PAGE8_MASK : PAGE4_MASK))
    else $error("page mask wrong");
  a_inv_match: assert property (cache_inv_valid_out |-> $past(status_reg_out[13]) &&
    cache_inv_match_out == ($past(areg_value_in) & cache_inv_mask_out)) else $error("bad match");
  a_restore_priv: assert property (restore_valid_out |-> $past(status_reg_out[13]) &&
    restore_coproc_id_out != CPID_NONE) else $error("restore issued wrongly");
  a_trap_quiet: assert property (exc_privilege_out || exc_illegal_out |->
    !(fp_cmd_valid_out || cache_inv_valid_out || restore_valid_out)) else $error("trap issued op");
endmodule
bind fpd_decoder fpd_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

//--- dv/fpd_fetch_model.sv
// Instruction fetch side: hands words to the decoder one per cycle.
// Assumes the bench calls send and idle from one process.
`timescale 1ns/1ps
`default_nettype none
module fpd_fetch_model
(
  // Clock
  input wire logic         clock_in,
  // Word stream
  output logic             valid_out,
  output logic [15:0]      word_out
);
  logic        tog = 1'b0;
  logic [15:0] word_q = 16'h0;
  initial valid_out = 1'b0;
  // Idle words toggle every cycle so stale data never passes as a match
  always @(posedge clock_in) tog <= ~tog;
  assign word_out = valid_out ? word_q : {16{tog}};
  // Words leave right after an edge and hold until the taking edge
  task automatic send(input logic [15:0] w);
    @(posedge clock_in);
    valid_out <= 1'b1;
    word_q <= w;
  endtask
  task automatic idle;
    @(posedge clock_in);
    valid_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the FP and privileged decoder.
// Assumes the fetch model and the bound checker sit beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpd_pkg::*;
  logic clock_in = 0, rstn_in = 0, ce_in = 1, page_8k_in = 0, reg_write_in = 0, reg_read_in = 0;
  logic word_valid_in, fp_cmd_valid_out, fp_is_power_of_two_out, fp_mem_source_out;
  logic fp_dest_write_out, cache_inv_valid_out, cache_inv_data_out, cache_inv_instr_out;
  logic restore_valid_out, exc_privilege_out, exc_illegal_out, exc_line_f_out, exc_unimp_type_out;
  logic [15:0] word_in, status_reg_out;
  logic [3:0]  reg_addr_in = 0;
  logic [31:0] reg_wdata_in = 0, areg_value_in = 0, reg_rdata_out, cache_inv_match_out;
  logic [31:0] cache_inv_mask_out, r, m;
  logic [2:0]  fp_src_reg_out, fp_format_out, fp_dest_register_out, fp_coproc_id_out;
  logic [2:0]  restore_coproc_id_out, f, md [6] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h4, 3'h2};
  logic [1:0]  cache_inv_scope_out;
  logic [7:0]  fp_exc_clear_mask_out;
  logic [6:0]  evec;
  int          mismatches = 0, check_count = 0, seed = 32'he9b9b977, sr;
  // Event pulses gathered: cmd, inv, restore, priv, illegal, line F, unimp
  assign evec = {fp_cmd_valid_out, cache_inv_valid_out, restore_valid_out, exc_privilege_out,
                 exc_illegal_out, exc_line_f_out, exc_unimp_type_out};
  fpd_decoder DUT (.*);
  fpd_fetch_model u_fetch (.clock_in(clock_in), .valid_out(word_valid_in), .word_out(word_in));
  // 250 MHz clock
  always #2 clock_in = ~clock_in;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= wr;
    reg_read_in <= !wr;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
    reg_read_in <= 1'b0;
    #1;
  endtask
  // Issues one op; pulses are looked at in the cycle they stand
  task automatic run(input logic [15:0] w0, w1, input bit two, input logic [6:0] ev, keep);
    u_fetch.send(w0);
    if (two) u_fetch.send(w1);
    u_fetch.idle;
    #1 chk("events", evec & keep, ev);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #20us;
    mismatches++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    sr = 32'h2700;
    #1 chk("reset", {fp_format_out, fp_coproc_id_out, status_reg_out}, {FMT_EXT, CPID_FPU, 16'h2700});
    bus(1'b1, 4'h0, 32'h0000_271F);
    sr = 32'h271F;
    bus(1'b0, 4'h0, 32'h0);
    chk("sr read", reg_rdata_out, sr);
    bus(1'b0, 4'hF, 32'h0);
    chk("unmapped", reg_rdata_out, 32'h0);
    $display("register bus test done");
    for (int k = 0; k < 14; k++)
    begin
      r = $random(seed);
      f = 3'(k % 7);
      run(16'hF210, {3'b010, f, r[2:0], (k < 7) ? OPMODE_TEST : OPMODE_POW2}, 1,
          (f == FMT_PACKED) ? 7'h01 : 7'h40, 7'h7F);
      if (f != FMT_PACKED) chk("fp cmd", {fp_format_out, fp_mem_source_out, fp_dest_write_out,
        fp_is_power_of_two_out, fp_exc_clear_mask_out},
        {f, 1'b1, k >= 7, k >= 7, (k < 7) ? 8'hBF : 8'hA5});
    end
    r = $random(seed);
    // Register source leaves the address field all zero
    run(16'hF200, {3'b000, r[2:0], r[2:0], OPMODE_POW2}, 1, 7'h40, 7'h7F);
    chk("pow2 reg", {fp_src_reg_out, fp_dest_register_out, fp_format_out, fp_mem_source_out,
      fp_coproc_id_out}, {r[2:0], r[2:0], FMT_EXT, 1'b0, CPID_FPU});
    for (int k = 0; k < 4; k++)
      run((k == 1) ? 16'hF208 : (k == 3) ? 16'hF23C : 16'hF200, {3'b010,
        (k == 0) ? FMT_DOUBLE : (k == 2) ? FMT_BYTE : FMT_SINGLE, 3'b000, OPMODE_TEST}, 1,
        (k < 2) ? 7'h04 : 7'h40, 7'h7F);
    $display("fp decode test done");
    for (int k = 0; k < 16; k++)
    begin
      r = $random(seed);
      areg_value_in <= r;
      page_8k_in <= r[31];
      m = (k[1:0] == 1) ? LINE_MASK : (k[1:0] == 2) ? (r[31] ? PAGE8_MASK : PAGE4_MASK) : 0;
      run({8'hF4, k[3:2], 1'b0, k[1:0], r[2:0]}, 16'h0, 0, (k[1:0] == 0) ? 7'h04 :
        (k[3:2] == 0) ? 7'h00 : 7'h20, (k[3:2] == 0) ? 7'h5F : 7'h7F);
      if (k[1:0] != 0 && k[3:2] != 0)
      begin
        chk("inv sel", {cache_inv_data_out, cache_inv_instr_out, cache_inv_scope_out},
          {k[2], k[3], k[1:0]});
        chk("inv addr", {cache_inv_mask_out ^ cache_inv_match_out}, m ^ (r & m));
      end
    end
    for (int k = 0; k < 6; k++)
    begin
      run({4'hF, (k == 5) ? CPID_NONE : CPID_FPU, 3'b101, md[k], 3'b001}, 16'h0, 0,
        (k < 2) ? 7'h10 : (k < 5) ? 7'h04 : 7'h02, 7'h7F);
      if (k < 2) chk("restore id", restore_coproc_id_out, CPID_FPU);
    end
    // Clock enable low: a word offered now must leave no trace
    @(posedge clock_in);
    ce_in <= 1'b0;
    run(16'hF4D8, 16'h0, 0, 7'h00, 7'h7F);
    ce_in <= 1'b1;
    $display("cache and restore test done");
    r = $random(seed) | 32'h0000_2000;
    run(ANDI_SR_OPCODE, r[15:0], 1, 7'h00, 7'h7F);
    sr = sr & r[15:0];
    chk("sr and", status_reg_out, sr);
    run(ANDI_SR_OPCODE, 16'hDFFF, 1, 7'h00, 7'h7F);
    sr = sr & 32'hDFFF;
    run(16'hF4D8, 16'h0, 0, 7'h08, 7'h7F);
    run(16'hF350, 16'h0, 0, 7'h08, 7'h7F);
    // The privilege trap pulses after the opcode word, so the immediate follows alone
    run(ANDI_SR_OPCODE, 16'h0, 0, 7'h08, 7'h7F);
    run(16'h0000, 16'h0, 0, 7'h00, 7'h7F);
    bus(1'b0, 4'h0, 32'h0);
    chk("sr kept", reg_rdata_out, sr);
    $display("privilege test done");
    final_report;
  end
endmodule
`default_nettype wire

//--- rtl/fpd_decoder.sv
// Main decoder for FP test/power-of-two and privileged SR, cache, restore ops.
// Assumes one instruction word per cycle while word_valid_in is high, with
// extension words following the opcode word directly.
`timescale 1ns/1ps
`default_nettype none

module fpd_decoder
  import fpd_pkg::*;
#(
  parameter int  ADDR_W        = 32,
  parameter bit  INTEGRATED_FPU = 1'b1,
  parameter bit  ENHANCED_CORE  = 1'b1
)
(
  // Clock, reset, enable
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire logic              ce_in,
  // Instruction stream
  input  wire logic              word_valid_in,
  input  wire logic [15:0]       word_in,
  // Core context
  input  wire logic              page_8k_in,
  input  wire logic [ADDR_W-1:0] areg_value_in,
  // Register-bus port
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic [31:0]            reg_rdata_out,
  // Floating-point command
  output logic                   fp_cmd_valid_out,
  output logic                   fp_is_power_of_two_out,
  output logic                   fp_mem_source_out,
  output logic [2:0]             fp_src_reg_out,
  output logic [2:0]             fp_format_out,
  output logic [2:0]             fp_dest_register_out,
  output logic                   fp_dest_write_out,
  output logic [2:0]             fp_coproc_id_out,
  output logic [7:0]             fp_exc_clear_mask_out,
  // Status register
  output logic [15:0]            status_reg_out,
  // Cache invalidation
  output logic                   cache_inv_valid_out,
  output logic                   cache_inv_data_out,
  output logic                   cache_inv_instr_out,
  output logic [1:0]             cache_inv_scope_out,
  output logic [ADDR_W-1:0]      cache_inv_match_out,
  output logic [ADDR_W-1:0]      cache_inv_mask_out,
  // Coprocessor restore
  output logic                   restore_valid_out,
  output logic [2:0]             restore_coproc_id_out,
  // Exceptions
  output logic                   exc_privilege_out,
  output logic                   exc_illegal_out,
  output logic                   exc_line_f_out,
  output logic                   exc_unimp_type_out
);
  import fpd_pkg::*;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_SR_ADDR   = 4'h0_0;
  localparam logic [3:0] REG_STAT_ADDR = 4'h0_1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] scope_mask(input logic [1:0] sc, input logic p8);
    scope_mask = '1;
    if (sc == SCOPE_LINE)
      scope_mask = LINE_MASK[ADDR_W-1:0];
    else if (sc == SCOPE_PAGE)
      scope_mask = p8 ? PAGE8_MASK[ADDR_W-1:0] : PAGE4_MASK[ADDR_W-1:0];
    else if (sc == SCOPE_ALL)
      scope_mask = '0;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fpd_state_t state_ff;
  fpd_state_t nxt_state;
  logic [15:0] op_ff;
  logic [15:0] sr_ff;
  logic [15:0] nxt_sr;
  logic [7:0]  trap_count_ff;
  fpd_ea_if    ea_bus ();

  wire logic supervisor = sr_ff[13];
  wire logic is_line_f  = (word_in[15:12] == LINE_F_NIBBLE);
  wire logic is_cpgen   = is_line_f && (word_in[8:6] == CPGEN_TYPE) && (word_in[11:9] != 3'h0_2);
  wire logic is_restore = is_line_f && (word_in[8:6] == COPROC_STATE_RESTORE_TYPE);
  wire logic is_cache_invalidate    = (word_in[15:8] == CACHE_INVALIDATE_TOP_BYTE) && !word_in[5];
  wire logic is_andi    = (word_in == ANDI_SR_OPCODE);

  // Command-word fields, checked against the opcode word held in op_ff
  wire logic       rm_bit   = word_in[RM_BIT];
  wire logic [2:0] src_fld  = word_in[SRC_LSB +: 3];
  wire logic [2:0] dst_fld  = word_in[DST_LSB +: 3];
  wire logic [6:0] opmode   = word_in[6:0];
  wire logic       fp_known = (word_in[15] == 1'b0) && (word_in[13] == 1'b0)
                              && ((opmode == OPMODE_TEST) || (opmode == OPMODE_POW2));

  // EA check request: opcode word during restore decode, held op during FP cmd
  always_comb
  begin
    ea_bus.restore_kind = (state_ff == FPD_OPWORD);
    ea_bus.mode = (state_ff == FPD_OPWORD) ? word_in[5:3] : op_ff[5:3];
    ea_bus.regn = (state_ff == FPD_OPWORD) ? word_in[2:0] : op_ff[2:0];
    ea_bus.fmt  = src_fld;
  end

  fpd_ea_check u_ea_check (
    .ea (ea_bus.chk)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FPD_OPWORD:
        if (word_valid_in && is_andi)
          nxt_state = FPD_IMMWORD;
        else if (word_valid_in && is_cpgen)
          nxt_state = FPD_CMDWORD;
      FPD_CMDWORD, FPD_IMMWORD:
        if (word_valid_in)
          nxt_state = FPD_OPWORD;
      default:
        nxt_state = FPD_OPWORD;
    endcase
  end

  // Phase register and held opcode word
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= FPD_OPWORD;
      op_ff    <= 16'h0000;
    end
    else if (ce_in)
    begin
      state_ff <= nxt_state;
      if (word_valid_in && (state_ff == FPD_OPWORD))
        op_ff <= word_in;
    end
  end

  // ----------------------------------------------------------------
  // Status register: trap leaves it alone; software may write it directly
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_sr = sr_ff;
    if (word_valid_in && (state_ff == FPD_IMMWORD) && supervisor)
      nxt_sr = sr_ff & word_in;
    else if (reg_write_in && (reg_addr_in == REG_SR_ADDR))
      nxt_sr = reg_wdata_in[15:0];
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      sr_ff <= SR_RESET;
    else if (ce_in)
      sr_ff <= nxt_sr;
  end

  // ----------------------------------------------------------------
  // Floating-point command issue
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fp_cmd_valid_out       <= 1'b0;
      fp_is_power_of_two_out <= 1'b0;
      fp_mem_source_out      <= 1'b0;
      fp_src_reg_out         <= 3'h0_0;
      fp_format_out          <= FMT_EXT;
      fp_dest_register_out   <= 3'h0_0;
      fp_dest_write_out      <= 1'b0;
      fp_coproc_id_out       <= CPID_FPU;
      fp_exc_clear_mask_out  <= 8'h00;
    end
    else if (ce_in)
    begin
      fp_cmd_valid_out <= 1'b0;
      if (word_valid_in && (state_ff == FPD_CMDWORD) && fp_known
          && (!rm_bit || ea_bus.legal)
          && !(INTEGRATED_FPU && rm_bit && (src_fld == FMT_PACKED)))
      begin
        fp_cmd_valid_out       <= 1'b1;
        fp_coproc_id_out       <= op_ff[CPID_LSB +: 3];
        fp_mem_source_out      <= rm_bit;
        // Register source names the FP register, memory source the format
        fp_src_reg_out         <= rm_bit ? 3'h0_0 : src_fld;
        fp_format_out          <= rm_bit ? src_fld : FMT_EXT;
        fp_dest_register_out   <= dst_fld;
        fp_is_power_of_two_out <= (opmode == OPMODE_POW2);
        fp_dest_write_out      <= (opmode == OPMODE_POW2);
        if (opmode == OPMODE_POW2)
          fp_exc_clear_mask_out <= 8'h00 | (8'h01 << EXC_BRANCH_UNORDERED_EXC) | (8'h01 << EXC_OPERAND_ERROR_EXC)
                                   | (8'h01 << EXC_DZ)
                                   | ((rm_bit && (src_fld == FMT_PACKED))
                                      ? 8'h00 : (8'h01 << EXC_DECIMAL_INPUT_INEXACT));
        else
          fp_exc_clear_mask_out <= 8'hBF
                                   & ((rm_bit && (src_fld == FMT_PACKED))
                                      ? 8'hFE : 8'hFF);
      end
    end
  end

  // ----------------------------------------------------------------
  // Cache invalidation and coprocessor restore requests
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cache_inv_valid_out   <= 1'b0;
      cache_inv_data_out    <= 1'b0;
      cache_inv_instr_out   <= 1'b0;
      cache_inv_scope_out   <= SCOPE_ILL;
      cache_inv_match_out   <= '0;
      cache_inv_mask_out    <= '0;
      restore_valid_out     <= 1'b0;
      restore_coproc_id_out <= 3'h0_0;
    end
    else if (ce_in)
    begin
      cache_inv_valid_out <= 1'b0;
      restore_valid_out   <= 1'b0;
      if (word_valid_in && (state_ff == FPD_OPWORD))
      begin
        // Dirty data is discarded: no push request is ever raised here
        if (is_cache_invalidate && supervisor && (word_in[4:3] != SCOPE_ILL))
        begin
          cache_inv_valid_out <= 1'b1;
          cache_inv_data_out  <= word_in[CACHE_LSB];
          cache_inv_instr_out <= word_in[CACHE_LSB+1];
          cache_inv_scope_out <= word_in[SCOPE_LSB +: 2];
          cache_inv_mask_out  <= scope_mask(word_in[SCOPE_LSB +: 2], page_8k_in);
          cache_inv_match_out <= areg_value_in
                                 & scope_mask(word_in[SCOPE_LSB +: 2], page_8k_in);
        end
        if (is_restore && supervisor && ea_bus.legal
            && !(ENHANCED_CORE && (word_in[CPID_LSB +: 3] == CPID_NONE)))
        begin
          restore_valid_out     <= 1'b1;
          restore_coproc_id_out <= word_in[CPID_LSB +: 3];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception flags, one-cycle pulses after the offending word
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      exc_privilege_out  <= 1'b0;
      exc_illegal_out    <= 1'b0;
      exc_line_f_out     <= 1'b0;
      exc_unimp_type_out <= 1'b0;
    end
    else if (ce_in)
    begin
      exc_privilege_out  <= 1'b0;
      exc_illegal_out    <= 1'b0;
      exc_line_f_out     <= 1'b0;
      exc_unimp_type_out <= 1'b0;
      if (word_valid_in && (state_ff == FPD_OPWORD))
      begin
        if ((is_andi || is_cache_invalidate || is_restore) && !supervisor)
          exc_privilege_out <= 1'b1;
        else if (is_cache_invalidate && (word_in[4:3] == SCOPE_ILL))
          exc_illegal_out <= 1'b1;
        else if (is_restore && ENHANCED_CORE && (word_in[CPID_LSB +: 3] == CPID_NONE))
          exc_line_f_out <= 1'b1;
        else if (is_restore && !ea_bus.legal)
          exc_illegal_out <= 1'b1;
      end
      if (word_valid_in && (state_ff == FPD_CMDWORD))
      begin
        // Destination field is never checked, so the test op never traps on it
        if (!fp_known || (rm_bit && !ea_bus.legal))
          exc_illegal_out <= 1'b1;
        else if (INTEGRATED_FPU && rm_bit && (src_fld == FMT_PACKED))
          exc_unimp_type_out <= 1'b1;
      end
    end
  end

  // Trap counter, visible to software for bring-up diagnostics
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      trap_count_ff <= 8'h00;
    else if (ce_in && (exc_privilege_out || exc_illegal_out
                       || exc_line_f_out || exc_unimp_type_out))
      trap_count_ff <= trap_count_ff + 8'h01;
  end

  // ----------------------------------------------------------------
  // Register read and status output
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (ce_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
      if (reg_read_in && (reg_addr_in == REG_SR_ADDR))
        reg_rdata_out <= {16'h0000, sr_ff};
      else if (reg_read_in && (reg_addr_in == REG_STAT_ADDR))
        reg_rdata_out <= {22'h00_0000, state_ff, trap_count_ff};
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      status_reg_out <= SR_RESET;
    else if (ce_in)
      status_reg_out <= nxt_sr;
  end

endmodule
`default_nettype wire

//--- rtl/fpd_ea_check.sv
// Effective-address legality checker for FP memory sources and restores.
// Assumes the requester holds inputs steady for the cycle it samples legal.
`timescale 1ns/1ps
`default_nettype none
module fpd_ea_check
  import fpd_pkg::*;
(
  fpd_ea_if.chk ea
);
  import fpd_pkg::*;

  // Plain data operand formats may come from a data register
  function automatic logic small_fmt(input logic [2:0] f);
    small_fmt = (f == FMT_BYTE) || (f == FMT_WORD) || (f == FMT_LONG) || (f == FMT_SINGLE);
  endfunction

  // Verdict: restore allows postinc and control, FP source allows data modes
  always_comb
  begin
    ea.legal = 1'b0;
    if (ea.restore_kind)
    begin
      case (ea.mode)
        MODE_DREG, MODE_AREG, MODE_PREDEC: ea.legal = 1'b0;
        MODE_EXT:  ea.legal = (ea.regn == 3'h0_0) || (ea.regn == 3'h0_1);
        default:   ea.legal = 1'b1;
      endcase
    end
    else
    begin
      case (ea.mode)
        MODE_DREG: ea.legal = small_fmt(ea.fmt);
        MODE_AREG: ea.legal = 1'b0;
        MODE_EXT:  ea.legal = (ea.regn <= REG_MAXABS);
        default:   ea.legal = 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- rtl/fpd_ea_if.sv
// Interface carrying one effective-address check request and its verdict.
// Assumes the checker is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface fpd_ea_if;
  logic [2:0] mode;
  logic [2:0] regn;
  logic [2:0] fmt;
  logic       restore_kind;
  logic       legal;
  modport req (output mode, output regn, output fmt, output restore_kind, input legal);
  modport chk (input mode, input regn, input fmt, input restore_kind, output legal);
endinterface
`default_nettype wire

//--- rtl/fpd_pkg.sv
// Package for the FP and privileged instruction decoder.
// Assumes a 16-bit instruction stream, words presented one at a time.
package fpd_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [3:0]  LINE_F_NIBBLE   = 4'h0_00F;
  localparam logic [15:0] ANDI_SR_OPCODE  = 16'h0_27C;
  localparam logic [7:0]  CACHE_INVALIDATE_TOP_BYTE   = 8'h0_F4;
  localparam logic [2:0]  CPGEN_TYPE      = 3'h0_0;
  localparam logic [2:0]  COPROC_STATE_RESTORE_TYPE  = 3'h0_5;
  localparam logic [6:0]  OPMODE_TEST     = 7'h0_3A;
  localparam logic [6:0]  OPMODE_POW2     = 7'h0_11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CPID_LSB     = 9;
  localparam int CPTYPE_LSB   = 6;
  localparam int EA_MODE_LSB  = 3;
  localparam int RM_BIT       = 14;
  localparam int SRC_LSB      = 10;
  localparam int DST_LSB      = 7;
  localparam int CACHE_LSB    = 6;
  localparam int SCOPE_LSB    = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_LONG    = 3'h0_0;
  localparam logic [2:0] FMT_SINGLE  = 3'h0_1;
  localparam logic [2:0] FMT_EXT     = 3'h0_2;
  localparam logic [2:0] FMT_PACKED  = 3'h0_3;
  localparam logic [2:0] FMT_WORD    = 3'h0_4;
  localparam logic [2:0] FMT_DOUBLE  = 3'h0_5;
  localparam logic [2:0] FMT_BYTE    = 3'h0_6;
  localparam logic [2:0] MODE_DREG   = 3'h0_0;
  localparam logic [2:0] MODE_AREG   = 3'h0_1;
  localparam logic [2:0] MODE_IND    = 3'h0_2;
  localparam logic [2:0] MODE_POSTI  = 3'h0_3;
  localparam logic [2:0] MODE_PREDEC = 3'h0_4;
  localparam logic [2:0] MODE_EXT    = 3'h0_7;
  localparam logic [2:0] REG_IMM     = 3'h0_4;
  localparam logic [2:0] REG_MAXABS  = 3'h0_4;
  localparam logic [1:0] SCOPE_ILL   = 2'h0_0;
  localparam logic [1:0] SCOPE_LINE  = 2'h0_1;
  localparam logic [1:0] SCOPE_PAGE  = 2'h0_2;
  localparam logic [1:0] SCOPE_ALL   = 2'h0_3;
  localparam logic [2:0] CPID_NONE   = 3'h0_0;
  localparam logic [2:0] CPID_FPU    = 3'h0_1;

  // ----------------------------------------------------------------
  // Address masks and status bit positions
  // ----------------------------------------------------------------
  localparam logic [31:0] LINE_MASK  = 32'hFFFF_FFF0;
  localparam logic [31:0] PAGE4_MASK = 32'hFFFF_F000;
  localparam logic [31:0] PAGE8_MASK = 32'hFFFF_E000;
  localparam int EXC_BRANCH_UNORDERED_EXC  = 7;
  localparam int EXC_SIGNALING_NAN_EXC  = 6;
  localparam int EXC_OPERAND_ERROR_EXC = 5;
  localparam int EXC_OVERFLOW_EXC  = 4;
  localparam int EXC_UNDERFLOW_EXC  = 3;
  localparam int EXC_DZ    = 2;
  localparam int EXC_RESULT_INEXACT = 1;
  localparam int EXC_DECIMAL_INPUT_INEXACT = 0;
  localparam logic [15:0] SR_RESET = 16'h2700;

  // Decoder phase
  typedef enum logic [1:0] {FPD_OPWORD, FPD_CMDWORD, FPD_IMMWORD} fpd_state_t;

endpackage
